//--- hw/boot_cfg_pkg.sv
// package: constants, register map and states of the power-on configuration loader
package boot_cfg_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_MODE = 8'h00;
   localparam logic [7:0] OFS_CTRL = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_IP = 8'h0C;
   localparam logic [7:0] OFS_NV_IP = 8'h10;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
   // mode switch bit positions (switch n sits at bit n-1)
   localparam int SW_TEST = 7;
   localparam int SW_UPDATE = 6;
   localparam int SW_STORED = 5;
   localparam int SW_TOOL = 4;
   // control register bits (software writes, all one-cycle strobes)
   localparam int CTRL_TESTS_PASS = 0;
   localparam int CTRL_TESTS_FAIL = 1;
   localparam int CTRL_ERROR = 2;
   // interrupt / event bits
   localparam int EV_READY = 0;
   localparam int EV_ERROR = 1;
   localparam int EV_RARP = 2;
   localparam int EV_NV_WRITE = 3;
   localparam int EV_W = 4;
   // reset values
   localparam logic [31:0] IP_RST = 32'h0000_0000;
   localparam logic [EV_W-1:0] MASK_RST = 4'h0;
   // timing
   localparam int CLK_MHZ = 250;
   localparam int BLINK_MS = 250;
   localparam int RARP_RETRY_MS = 1000;
   localparam int BLINK_CYC = BLINK_MS * CLK_MHZ * 1000;
   localparam int RARP_RETRY_CYC = RARP_RETRY_MS * CLK_MHZ * 1000;
   // boot sequencer
   typedef enum logic [2:0] {
      ST_SELFTEST = 3'b000,
      ST_LOAD_NV = 3'b001,
      ST_RARP = 3'b011,
      ST_WAIT_TOOL = 3'b010,
      ST_STORE = 3'b110,
      ST_READY = 3'b111,
      ST_FAULT = 3'b101,
      ST_SPECIAL = 3'b100
   } boot_state_t;
endpackage

//--- hw/boot_mode_ip_config.sv
// power-on mode and IP address configuration loader with AHB-Lite registers
// Functional notes
// - switch 8 on selects extended factory test
// - factory test fails without both loopbacks
// - switch 7 on selects firmware update mode while switch 8 off
// - switch 6 on loads stored address, no wait
// - switch 6 off gets address from network
// - RARP mode repeats requests until valid reply
// - tool mode sends no RARP, awaits assignment
// - switch 5 ignored while switch 6 on
// - network address written to nonvolatile store
// - slide switch picks native or AUI port
// - ready flashes in tests, steady once configured
// - on error ready keeps flashing
`timescale 1ns/1ps
module boot_mode_ip_config
   import boot_cfg_pkg::*;
#(
   parameter int BLINK_CYCLES = BLINK_CYC,
   parameter int RETRY_CYCLES = RARP_RETRY_CYC
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // switches
   input wire logic [7:0] mode_sw,
   input wire logic port_sw,
   // loopback detection for factory test
   input wire logic bus_loop_ok,
   input wire logic eth_loop_ok,
   // network side
   output logic rarp_req,
   input wire logic rarp_reply_valid,
   input wire logic [31:0] rarp_ip,
   input wire logic tool_assign_valid,
   input wire logic [31:0] tool_ip,
   // nonvolatile address store
   input wire logic [31:0] nv_ip,
   output logic nv_we,
   output logic [31:0] nv_wdata,
   // mode and status outputs
   output logic factory_test,
   output logic fw_update,
   output logic aui_sel,
   output logic ready_led,
   output logic irq
);
   import boot_cfg_pkg::*;

   logic sampled_ff;
   logic [7:0] mode_ff;
   logic port_ff;
   boot_state_t state_ff, nxt_state;
   logic [31:0] ip_ff;
   logic [31:0] blink_cnt_ff;
   logic blink_ff;
   logic [31:0] retry_cnt_ff;
   logic rarp_req_ff;
   logic nv_we_ff;
   logic [31:0] nv_wdata_ff;
   logic test_fail_ff;
   logic [EV_W-1:0] irq_stat_ff, irq_mask_ff;
   logic dp_wr_ff;
   logic [7:0] dp_addr_ff;
   logic [31:0] hrdata_ff;

   // switches are caught one edge after release, never under reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sampled_ff <= 1'b0;
         mode_ff <= 8'h00;
         port_ff <= 1'b0;
      end else if (!sampled_ff) begin
         sampled_ff <= 1'b1;
         mode_ff <= mode_sw;
         port_ff <= port_sw;
      end
   end

   assign factory_test = mode_ff[SW_TEST];
   assign fw_update = mode_ff[SW_UPDATE] & ~mode_ff[SW_TEST];
   assign aui_sel = port_ff;

   // ahb-lite address phase capture
   wire addr_ok = hsel & hready & htrans[1];
   wire wr_phase = addr_ok & hwrite;
   wire [31:0] wdata_mask = hwdata;
   wire ctrl_wr = dp_wr_ff & (dp_addr_ff == OFS_CTRL);
   wire sw_pass = ctrl_wr & wdata_mask[CTRL_TESTS_PASS];
   wire sw_fail = ctrl_wr & wdata_mask[CTRL_TESTS_FAIL];
   wire sw_error = ctrl_wr & wdata_mask[CTRL_ERROR];
   wire stat_wr = dp_wr_ff & (dp_addr_ff == OFS_IRQ_STAT);
   wire mask_wr = dp_wr_ff & (dp_addr_ff == OFS_IRQ_MASK);

   // factory test cannot pass without both loopbacks present
   wire tests_ok = sw_pass & (~mode_ff[SW_TEST] | (bus_loop_ok & eth_loop_ok));
   wire tests_bad = sw_fail | (sw_pass & ~tests_ok);
   wire use_stored = mode_ff[SW_STORED];
   wire use_tool = mode_ff[SW_TOOL] & ~use_stored;

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_SELFTEST: begin
            if (tests_bad) nxt_state = ST_FAULT;
            else if (tests_ok && (mode_ff[SW_TEST] || fw_update)) nxt_state = ST_SPECIAL;
            else if (tests_ok && use_stored) nxt_state = ST_LOAD_NV;
            else if (tests_ok && use_tool) nxt_state = ST_WAIT_TOOL;
            else if (tests_ok) nxt_state = ST_RARP;
         end
         ST_LOAD_NV: nxt_state = ST_READY;
         ST_RARP: if (rarp_reply_valid) nxt_state = ST_STORE;
         ST_WAIT_TOOL: if (tool_assign_valid) nxt_state = ST_STORE;
         ST_STORE: nxt_state = ST_READY;
         ST_READY: ;
         ST_FAULT: ;
         ST_SPECIAL: ;
      endcase
      if (sw_error && state_ff != ST_SELFTEST) nxt_state = ST_FAULT;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) state_ff <= ST_SELFTEST;
      else if (sampled_ff) state_ff <= nxt_state;
   end

   // address capture and nonvolatile write-back
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ip_ff <= IP_RST;
         nv_we_ff <= 1'b0;
         nv_wdata_ff <= IP_RST;
      end else begin
         nv_we_ff <= 1'b0;
         if (state_ff == ST_LOAD_NV) ip_ff <= nv_ip;
         if (state_ff == ST_RARP && rarp_reply_valid) ip_ff <= rarp_ip;
         if (state_ff == ST_WAIT_TOOL && tool_assign_valid) ip_ff <= tool_ip;
         if (state_ff == ST_STORE) begin
            nv_we_ff <= 1'b1;
            nv_wdata_ff <= ip_ff;
         end
      end
   end
   assign nv_we = nv_we_ff;
   assign nv_wdata = nv_wdata_ff;

   // rarp retry timer: first request on entry, then once per retry period
   wire retry_due = (retry_cnt_ff == 32'h0000_0000);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         retry_cnt_ff <= 32'h0000_0000;
         rarp_req_ff <= 1'b0;
      end else begin
         rarp_req_ff <= (state_ff == ST_RARP) & retry_due & ~rarp_reply_valid;
         // held at zero outside the request state, so the first request leaves on entry
         if (state_ff != ST_RARP) retry_cnt_ff <= 32'h0000_0000;
         else if (retry_due) retry_cnt_ff <= 32'(RETRY_CYCLES - 1);
         else retry_cnt_ff <= retry_cnt_ff - 32'h0000_0001;
      end
   end
   assign rarp_req = rarp_req_ff;

   // ready indicator blink divider
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         blink_cnt_ff <= 32'h0000_0000;
         blink_ff <= 1'b0;
      end else if (blink_cnt_ff == 32'(BLINK_CYCLES - 1)) begin
         blink_cnt_ff <= 32'h0000_0000;
         blink_ff <= ~blink_ff;
      end else begin
         blink_cnt_ff <= blink_cnt_ff + 32'h0000_0001;
      end
   end
   assign ready_led = (state_ff == ST_READY) ? 1'b1 : blink_ff;

   // interrupts: set wins over write-one-to-clear
   wire [EV_W-1:0] ev;
   assign ev[EV_READY] = (state_ff != ST_READY) && (nxt_state == ST_READY) && sampled_ff;
   assign ev[EV_ERROR] = (state_ff != ST_FAULT) && (nxt_state == ST_FAULT) && sampled_ff;
   assign ev[EV_RARP] = rarp_req_ff;
   assign ev[EV_NV_WRITE] = nv_we_ff;
   wire [EV_W-1:0] clr = stat_wr ? hwdata[EV_W-1:0] : '0;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_stat_ff <= '0;
         irq_mask_ff <= MASK_RST;
         test_fail_ff <= 1'b0;
      end else begin
         irq_stat_ff <= (irq_stat_ff & ~clr) | ev;
         if (mask_wr) irq_mask_ff <= hwdata[EV_W-1:0];
         if (tests_bad) test_fail_ff <= 1'b1;
      end
   end
   assign irq = |(irq_stat_ff & irq_mask_ff);

   // bus data phase and read mux
   wire [31:0] status_word = {24'h00_0000, test_fail_ff, port_ff, 3'(state_ff),
      fw_update, factory_test, (state_ff == ST_READY)};
   wire [31:0] rd_mux =
      (haddr[7:0] == OFS_MODE) ? {24'h00_0000, mode_ff} :
      (haddr[7:0] == OFS_STATUS) ? status_word :
      (haddr[7:0] == OFS_IP) ? ip_ff :
      (haddr[7:0] == OFS_NV_IP) ? nv_ip :
      (haddr[7:0] == OFS_IRQ_STAT) ? {28'h000_0000, irq_stat_ff} :
      (haddr[7:0] == OFS_IRQ_MASK) ? {28'h000_0000, irq_mask_ff} : 32'h0000_0000;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_wr_ff <= 1'b0;
         dp_addr_ff <= 8'h00;
         hrdata_ff <= 32'h0000_0000;
      end else begin
         dp_wr_ff <= wr_phase;
         if (addr_ok) dp_addr_ff <= haddr[7:0];
         if (addr_ok && !hwrite) hrdata_ff <= rd_mux;
      end
   end
   assign hrdata = hrdata_ff;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // assertions
   sequence s_store;
      state_ff == ST_STORE;
   endsequence
   property p_nv_write;
      @(posedge hclk) disable iff (!hresetn) s_store |=> nv_we && nv_wdata == $past(ip_ff);
   endproperty
   a_nv_write: assert property (p_nv_write) else $error("address not stored");
   property p_tool_no_rarp;
      @(posedge hclk) disable iff (!hresetn) state_ff == ST_WAIT_TOOL |=> !rarp_req;
   endproperty
   a_tool_no_rarp: assert property (p_tool_no_rarp) else $error("rarp in tool mode");
   property p_stored;
      @(posedge hclk) disable iff (!hresetn)
         state_ff == ST_SELFTEST && tests_ok && use_stored && !factory_test && !fw_update
         |=> state_ff == ST_LOAD_NV ##1 state_ff == ST_READY;
   endproperty
   a_stored: assert property (p_stored) else $error("stored path wrong");
   property p_ignore5;
      @(posedge hclk) disable iff (!hresetn) use_stored |-> state_ff != ST_WAIT_TOOL;
   endproperty
   a_ignore5: assert property (p_ignore5) else $error("switch 5 not ignored");
   property p_steady;
      @(posedge hclk) disable iff (!hresetn) state_ff == ST_READY |-> ready_led;
   endproperty
   a_steady: assert property (p_steady) else $error("ready not steady");
   property p_fail_no_loop;
      @(posedge hclk) disable iff (!hresetn)
         state_ff == ST_SELFTEST && sw_pass && factory_test && !(bus_loop_ok && eth_loop_ok)
         |=> state_ff == ST_FAULT;
   endproperty
   a_fail_no_loop: assert property (p_fail_no_loop) else $error("test passed w/o loop");
   property p_hold_sw;
      @(posedge hclk) disable iff (!hresetn) sampled_ff |=> $stable(mode_ff) && $stable(port_ff);
   endproperty
   a_hold_sw: assert property (p_hold_sw) else $error("switches resampled");
   property p_rarp_first;
      @(posedge hclk) disable iff (!hresetn)
         $rose(state_ff == ST_RARP) && !rarp_reply_valid |=> rarp_req;
   endproperty
   a_rarp_first: assert property (p_rarp_first) else $error("no rarp request");
   property p_rarp_pulse;
      @(posedge hclk) disable iff (!hresetn) rarp_req |=> !rarp_req;
   endproperty
   a_rarp_pulse: assert property (p_rarp_pulse) else $error("rarp request too long");
   property p_nv_pulse;
      @(posedge hclk) disable iff (!hresetn) nv_we |=> !nv_we;
   endproperty
   a_nv_pulse: assert property (p_nv_pulse) else $error("store strobe too long");
   sequence s_reply;
      state_ff == ST_RARP && rarp_reply_valid && !sw_error;
   endsequence
   property p_reply_taken;
      @(posedge hclk) disable iff (!hresetn)
         s_reply |=> state_ff == ST_STORE && ip_ff == $past(rarp_ip);
   endproperty
   a_reply_taken: assert property (p_reply_taken) else $error("reply not taken");
   sequence s_tool;
      state_ff == ST_WAIT_TOOL && tool_assign_valid && !sw_error;
   endsequence
   property p_tool_taken;
      @(posedge hclk) disable iff (!hresetn)
         s_tool |=> state_ff == ST_STORE && ip_ff == $past(tool_ip);
   endproperty
   a_tool_taken: assert property (p_tool_taken) else $error("assignment not taken");
   sequence s_error_strobe;
      sampled_ff && sw_error && state_ff != ST_SELFTEST;
   endsequence
   property p_error_fault;
      @(posedge hclk) disable iff (!hresetn) s_error_strobe |=> state_ff == ST_FAULT;
   endproperty
   a_error_fault: assert property (p_error_fault) else $error("error not latched");
   property p_factory;
      @(posedge hclk) disable iff (!hresetn) sampled_ff && state_ff == ST_SELFTEST && tests_ok
         && !tests_bad && factory_test |=> state_ff == ST_SPECIAL;
   endproperty
   a_factory: assert property (p_factory) else $error("factory test not entered");
   property p_update;
      @(posedge hclk) disable iff (!hresetn) sampled_ff && state_ff == ST_SELFTEST && tests_ok
         && !tests_bad && fw_update |=> state_ff == ST_SPECIAL;
   endproperty
   a_update: assert property (p_update) else $error("update mode not entered");
endmodule // boot_mode_ip_config

//--- verification/addr_host_model.sv
// network host model: answers address requests and assigns addresses on command
`timescale 1ns/1ps
module addr_host_model (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // scenario control
   input wire logic [3:0] ignore_n,
   input wire logic [3:0] lat,
   input wire logic tool_go,
   input wire logic [31:0] ip,
   // device side
   input wire logic rarp_req,
   output logic rarp_reply_valid,
   output logic [31:0] rarp_ip,
   output logic tool_assign_valid,
   output logic [31:0] tool_ip
);
   int seen;
   int wait_c;
   logic [31:0] junk;
   // address lines churn outside a valid pulse, so a late capture is caught
   assign rarp_ip = rarp_reply_valid ? ip : junk;
   assign tool_ip = tool_assign_valid ? ip : ~junk;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         seen = 0;
         wait_c = -1;
         junk <= 32'h5A5A_0F0F;
         rarp_reply_valid <= 1'b0;
         tool_assign_valid <= 1'b0;
      end else begin
         junk <= junk + 32'h9E37_79B9;
         rarp_reply_valid <= 1'b0;
         tool_assign_valid <= tool_go;
         if (rarp_req === 1'b1) begin
            seen++;
            // a busy server drops the first requests; the device has to retry
            if (seen > ignore_n) wait_c = lat;
         end else if (wait_c > 0) begin
            wait_c--;
         end else if (wait_c == 0) begin
            rarp_reply_valid <= 1'b1;
            wait_c = -1;
         end
      end
   end
endmodule // addr_host_model

//--- verification/boot_mode_ip_config_bench.sv
// self-checking bench for the power-on mode and address loader
`timescale 1ns/1ps
module boot_mode_ip_config_bench;
   import boot_cfg_pkg::*;
   localparam int BLINK = 4;
   localparam int RETRY = 16;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, port_sw, bus_loop_ok, eth_loop_ok, p;
   logic [31:0] haddr, hwdata, hrdata, rarp_ip, tool_ip, nv_ip, nv_wdata, ip, m;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [7:0] mode_sw, s;
   logic [3:0] ignore_n, lat;
   logic rarp_req, rarp_reply_valid, tool_assign_valid, nv_we, factory_test, fw_update;
   logic aui_sel, ready_led, irq, tool_go, rd_dp;
   logic [31:0] rd_q[$], mk_q[$], nv_q[$];
   int fail_count = 0, cmp_count = 0, rq_n, gap, nv_n;

   boot_mode_ip_config #(.BLINK_CYCLES(BLINK), .RETRY_CYCLES(RETRY)) dut (.hclk, .hresetn,
      .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
      .hresp, .mode_sw, .port_sw, .bus_loop_ok, .eth_loop_ok, .rarp_req, .rarp_reply_valid,
      .rarp_ip, .tool_assign_valid, .tool_ip, .nv_ip, .nv_we, .nv_wdata, .factory_test,
      .fw_update, .aui_sel, .ready_led, .irq);
   addr_host_model host (.hclk, .hresetn, .ignore_n, .lat, .tool_go, .ip, .rarp_req,
      .rarp_reply_valid, .rarp_ip, .tool_assign_valid, .tool_ip);

   task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmp1(input logic got, input logic exp);
      cmp32({31'h0, got}, {31'h0, exp});
   endtask
   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // one single word transfer; a read notes its expectation for the monitor
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d, m);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= wr;
      hsize <= 3'b010;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      rd_dp <= !wr;
      if (!wr) rd_q.push_back(d);
      if (!wr) mk_q.push_back(m);
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd_dp <= 1'b0;
   endtask
   task automatic boot(input logic [7:0] sw, input logic ps);
      hresetn <= 1'b0;
      mode_sw <= sw;
      port_sw <= ps;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      ahb(1'b1, OFS_CTRL, 32'h1 << CTRL_TESTS_PASS, 32'h0);
   endtask
   task automatic led(input logic steady);
      int t;
      logic l;
      t = 0;
      l = ready_led;
      repeat (4 * BLINK) begin
         @(posedge hclk);
         if (ready_led !== l) t++;
         l = ready_led;
      end
      cmp1(steady ? (t == 0 && ready_led === 1'b1) : (t > 0), 1'b1);
   endtask
   task automatic wait_nv();
      for (int i = 0; i < 300 && nv_n == 0; i++) @(posedge hclk);
      repeat (4) @(posedge hclk);
   endtask

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rq_n = 0;
         nv_n = 0;
         gap = 0;
      end else begin
         gap++;
         if (rarp_req === 1'b1) begin
            if (rq_n > 0) cmp32(32'(gap), 32'(RETRY));
            gap = 0;
            rq_n++;
         end
         if (nv_we === 1'b1) begin
            nv_n++;
            cmp32(nv_wdata, nv_q.size() > 0 ? nv_q.pop_front() : ~nv_wdata);
         end
         if (rd_dp === 1'b1 && hreadyout === 1'b1) begin
            m = mk_q.pop_front();
            cmp32(hrdata & m, rd_q.pop_front() & m);
         end
      end
   end

   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end
   initial begin
      repeat (5000) @(posedge hclk);
      fail_count++;
      print_verdict();
   end

   initial begin
      {hresetn, hsel, hwrite, rd_dp, tool_go, port_sw, bus_loop_ok, eth_loop_ok} = '0;
      {haddr, hwdata, nv_ip, ip, htrans, hsize, mode_sw, ignore_n, lat} = '0;
      void'($urandom(32'h0064AB68));
      // stored address; switch 5 random since it has to be ignored
      s = {2'b00, 1'b1, 1'($urandom), 4'h0};
      p = 1'($urandom);
      nv_ip <= $urandom;
      boot(s, p);
      mode_sw <= s ^ 8'hF0;
      ahb(1'b0, OFS_IRQ_MASK, 32'h0, 32'hF);
      ahb(1'b0, OFS_MODE, {24'h0, s}, 32'hFF);
      ahb(1'b1, OFS_IRQ_MASK, 32'h1 << EV_READY, 32'h0);
      ahb(1'b0, OFS_STATUS, {25'h0, p, ST_READY, 3'b001}, 32'h7F);
      ahb(1'b0, OFS_IP, nv_ip, '1);
      ahb(1'b0, 8'h1C, 32'h0, '1);
      cmp1(aui_sel, p);
      cmp1(hresp, 1'b0);
      cmp1(irq, 1'b1);
      led(1'b1);
      cmp32(32'(rq_n), 32'd0);
      ahb(1'b1, OFS_IRQ_STAT, 32'hF, 32'h0);
      ahb(1'b1, OFS_CTRL, 32'h1 << CTRL_ERROR, 32'h0);
      ahb(1'b0, OFS_STATUS, {26'h0, ST_FAULT, 3'b000}, 32'h39);
      cmp1(irq, 1'b0);
      led(1'b0);
      // network request mode with a server that drops two requests
      ip <= $urandom;
      lat <= 4'($urandom_range(3));
      ignore_n <= 4'd2;
      nv_q.push_back(32'h0);
      boot(8'h00, 1'b0);
      nv_q[0] = ip;
      wait_nv();
      cmp32(32'(rq_n), 32'd3);
      ahb(1'b0, OFS_IP, ip, '1);
      ahb(1'b0, OFS_IRQ_STAT, 32'hD, 32'hF);
      // static assignment mode
      ip <= $urandom;
      boot(8'h10, 1'b1);
      nv_q.push_back(ip);
      tool_go <= 1'b1;
      @(posedge hclk);
      tool_go <= 1'b0;
      wait_nv();
      cmp32(32'(rq_n), 32'd0);
      ahb(1'b0, OFS_STATUS, {25'h0, 1'b1, ST_READY, 3'b001}, 32'h7F);
      // factory test over every loopback combination
      for (int k = 0; k < 4; k++) begin
         bus_loop_ok <= k[0];
         eth_loop_ok <= k[1];
         boot(8'h80, 1'b0);
         repeat (4) @(posedge hclk);
         ahb(1'b0, OFS_STATUS, {26'h0, k == 3 ? ST_SPECIAL : ST_FAULT, 3'b010}, 32'h3F);
         cmp1(factory_test, 1'b1);
      end
      boot(8'h40, 1'b0);
      repeat (4) @(posedge hclk);
      ahb(1'b0, OFS_STATUS, {26'h0, ST_SPECIAL, 3'b100}, 32'h3F);
      cmp1(fw_update, 1'b1);
      print_verdict();
   end
endmodule // boot_mode_ip_config_bench
